// ### spi_port_consts.vh
/*
 * constants for the radio serial slave port: control byte layout,
 * register space and buffer sizes.
 * assumes nothing; definitions only.
 */
`ifndef SPI_PORT_CONSTS_VH
`define SPI_PORT_CONSTS_VH

// ======================================================
// control byte fields
`define CTL_DIR_BIT      7
`define CTL_TGT_BIT      6
`define CTL_MODE_BIT     5
`define CTL_ADDR_MSB     5
`define REG_INDIRECT     6'h3f

// ======================================================
// sizes
`define BYTE_W           8
`define BIT_CNT_W        3
`define BIT_LAST         3'h7
`define BIT_FIRST        3'h0
`define REG_ADDR_W       8
`define BUF_ADDR_W       7
`define BUF_DEPTH        128
`define BUF_WRAP         7'h7f
`define ZERO_BYTE        8'h00

`endif

// ### pkt_buf_ram.v
/*
 * packet buffer memory: one write port, one read port, registered
 * read data.
 * assumes the caller sequences addresses on the core clock.
 */
`timescale 1ns/10ps
`include "spi_port_consts.vh"

module pkt_buf_ram (
   clk,
   we,
   waddr,
   wdata,
   raddr,
   rdata
);
   input  wire                      clk;
   input  wire                      we;
   input  wire [`BUF_ADDR_W-1:0]    waddr;
   input  wire [`BYTE_W-1:0]        wdata;
   input  wire [`BUF_ADDR_W-1:0]    raddr;
   output reg  [`BYTE_W-1:0]        rdata;

   reg [`BYTE_W-1:0] mem [0:`BUF_DEPTH-1];

   // no reset: memory contents are undefined until written
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

// ### radio_spi_slave_port.v
/*
 * serial slave port of the radio: decodes control byte, accesses
 * registers (direct, indirect, burst only) and packet buffer, burst or single.
 * assumes select, serial clock and mosi come from the host, unrelated
 * to clk; the core register file sits outside behind reg_* ports.
 */
`timescale 1ns/10ps
`include "spi_port_consts.vh"

module radio_spi_slave_port (
   clk,
   rst_n,
   ssel_n,
   sclk,
   mosi,
   miso_o,
   miso_oe,
   primary_irq_status,
   reg_wr,
   reg_rd,
   reg_addr,
   reg_wdata,
   reg_rdata
);
   input  wire                      clk;
   input  wire                      rst_n;
   input  wire                      ssel_n;
   input  wire                      sclk;
   input  wire                      mosi;
   output reg                       miso_o;
   output wire                      miso_oe;
   input  wire [`BYTE_W-1:0]        primary_irq_status;
   output reg                       reg_wr;
   output reg                       reg_rd;
   output reg  [`REG_ADDR_W-1:0]    reg_addr;
   output reg  [`BYTE_W-1:0]        reg_wdata;
   input  wire [`BYTE_W-1:0]        reg_rdata;

   // ======================================================
   // states, one-hot
   localparam [4:0] ST_CTL  = 5'h01;
   localparam [4:0] ST_ADR  = 5'h02;
   localparam [4:0] ST_DATA = 5'h04;
   localparam [4:0] ST_DONE = 5'h08;
   localparam [4:0] ST_IDLE = 5'h10;

   // ======================================================
   // pin synchronisers; first stage read only by the second
   reg [1:0] ssel_s_reg;
   reg [1:0] sclk_s_reg;
   reg [1:0] mosi_s_reg;
   reg       sclk_d_reg;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ssel_s_reg <= 2'h3;
         sclk_s_reg <= 2'h0;
         mosi_s_reg <= 2'h0;
         sclk_d_reg <= 1'b0;
      end else begin
         ssel_s_reg <= {ssel_s_reg[0], ssel_n};
         sclk_s_reg <= {sclk_s_reg[0], sclk};
         mosi_s_reg <= {mosi_s_reg[0], mosi};
         sclk_d_reg <= sclk_s_reg[1];
      end
   end

   wire sel      = ~ssel_s_reg[1];
   wire sclk_r   = sel & sclk_s_reg[1] & ~sclk_d_reg;
   wire sclk_f   = sel & ~sclk_s_reg[1] & sclk_d_reg;
   wire mosi_bit = mosi_s_reg[1];

   assign miso_oe = sel;

   // ======================================================
   // shift and transaction state
   reg [4:0]             state_reg;
   reg [`BIT_CNT_W-1:0]  bit_cnt_reg;
   reg [`BYTE_W-2:0]     rx_reg;
   reg [`BYTE_W-1:0]     tx_reg;
   reg                   is_read_reg;
   reg                   is_buf_reg;
   reg                   single_reg;
   reg                   load_pend_reg;
   reg [`REG_ADDR_W-1:0] addr_reg;
   reg                   buf_we;

   wire [`BYTE_W-1:0] rx_byte  = {rx_reg, mosi_bit};
   wire               byte_end = sclk_r & (bit_cnt_reg == `BIT_LAST);

   wire [`BYTE_W-1:0]     buf_rdata;
   wire [`BUF_ADDR_W-1:0] buf_addr = addr_reg[`BUF_ADDR_W-1:0];

   pkt_buf_ram u_buf (
      .clk   (clk),
      .we    (buf_we),
      .waddr (buf_addr),
      .wdata (rx_byte),
      .raddr (buf_addr),
      .rdata (buf_rdata)
   );

   always @* begin
      buf_we = byte_end & (state_reg == ST_DATA) & is_buf_reg
             & ~is_read_reg;
   end

   // next address after a data byte; buffer wraps at its end
   wire [`REG_ADDR_W-1:0] addr_inc = addr_reg + 8'h01;
   wire [`REG_ADDR_W-1:0] addr_nxt = is_buf_reg ?
        {1'b0, addr_inc[`BUF_ADDR_W-1:0] & `BUF_WRAP} : addr_inc;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= ST_IDLE;
         bit_cnt_reg   <= `BIT_FIRST;
         rx_reg        <= 7'h00;
         tx_reg        <= `ZERO_BYTE;
         miso_o        <= 1'b0;
         is_read_reg   <= 1'b0;
         is_buf_reg    <= 1'b0;
         single_reg    <= 1'b0;
         load_pend_reg <= 1'b0;
         addr_reg      <= `ZERO_BYTE;
         reg_wr        <= 1'b0;
         reg_rd        <= 1'b0;
         reg_addr      <= `ZERO_BYTE;
         reg_wdata     <= `ZERO_BYTE;
      end else begin
         reg_wr <= 1'b0;
         reg_rd <= 1'b0;
         if (!sel) begin
            state_reg     <= ST_IDLE;
            bit_cnt_reg   <= `BIT_FIRST;
            load_pend_reg <= 1'b0;
         end else begin
            if (state_reg == ST_IDLE) begin
               // status snapshot goes out first, msb leading
               state_reg   <= ST_CTL;
               tx_reg      <= primary_irq_status;
               miso_o      <= primary_irq_status[`BYTE_W-1];
               bit_cnt_reg <= `BIT_FIRST;
            end
            if (sclk_r) begin
               rx_reg      <= rx_byte[`BYTE_W-2:0];
               bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
            if (sclk_f) begin
               if (load_pend_reg) begin
                  load_pend_reg <= 1'b0;
                  miso_o        <= is_buf_reg ? buf_rdata[`BYTE_W-1]
                                              : reg_rdata[`BYTE_W-1];
                  tx_reg        <= is_buf_reg ? buf_rdata : reg_rdata;
               end else begin
                  miso_o <= tx_reg[`BYTE_W-2];
                  tx_reg <= {tx_reg[`BYTE_W-2:0], 1'b0};
               end
            end
            if (byte_end) begin
               case (state_reg)
                  ST_CTL: begin
                     is_read_reg <= rx_byte[`CTL_DIR_BIT];
                     is_buf_reg  <= rx_byte[`CTL_TGT_BIT];
                     if (rx_byte[`CTL_TGT_BIT]) begin
                        single_reg <= rx_byte[`CTL_MODE_BIT];
                        addr_reg   <= `ZERO_BYTE;
                        state_reg  <= rx_byte[`CTL_MODE_BIT] ? ST_ADR
                                                             : ST_DATA;
                        load_pend_reg <= rx_byte[`CTL_DIR_BIT]
                                        & ~rx_byte[`CTL_MODE_BIT];
                     end else if (rx_byte[`CTL_ADDR_MSB:0]
                                  == `REG_INDIRECT) begin
                        single_reg <= 1'b0;
                        state_reg  <= ST_ADR;
                     end else begin
                        single_reg <= 1'b0;
                        addr_reg   <= {2'h0, rx_byte[`CTL_ADDR_MSB:0]};
                        reg_addr   <= {2'h0, rx_byte[`CTL_ADDR_MSB:0]};
                        reg_rd     <= rx_byte[`CTL_DIR_BIT];
                        load_pend_reg <= rx_byte[`CTL_DIR_BIT];
                        state_reg  <= ST_DATA;
                     end
                     tx_reg <= `ZERO_BYTE;
                  end
                  ST_ADR: begin
                     addr_reg  <= is_buf_reg ?
                        {1'b0, rx_byte[`BUF_ADDR_W-1:0]} : rx_byte;
                     reg_addr  <= rx_byte;
                     reg_rd    <= is_read_reg & ~is_buf_reg;
                     load_pend_reg <= is_read_reg;
                     state_reg <= ST_DATA;
                  end
                  ST_DATA: begin
                     // handshake pulse in core domain
                     if (!is_read_reg && !is_buf_reg) begin
                        reg_wr    <= 1'b1;
                        reg_wdata <= rx_byte;
                     end
                     addr_reg  <= addr_nxt;
                     // a write pulse carries its own byte's address;
                     // reads fetch the next one ahead of time
                     reg_addr  <= is_read_reg ? addr_nxt : addr_reg;
                     reg_rd    <= is_read_reg & ~is_buf_reg & ~single_reg;
                     load_pend_reg <= is_read_reg & ~single_reg;
                     state_reg <= single_reg ? ST_DONE : ST_DATA;
                  end
                  ST_DONE: begin
                     state_reg <= ST_DONE;
                  end
                  default: begin
                     state_reg <= ST_IDLE;
                  end
               endcase
            end
         end
      end
   end
endmodule

// ### spi_port_chk_props.sv
/* checker for the serial slave port outputs.
   assumes it is bound to radio_spi_slave_port and sees only its ports. */
`timescale 1ns/10ps
module spi_port_chk (
   input wire clk,
   input wire rst_n,
   input wire ssel_n,
   input wire sclk,
   input wire miso_o,
   input wire miso_oe,
   input wire reg_wr,
   input wire reg_rd
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ======================================================
   // output relations
   a_oe_released: assert property (ssel_n [*3] |-> !miso_oe)
      else $error("miso driven while not selected");
   a_oe_driven: assert property (!ssel_n [*3] |-> miso_oe)
      else $error("miso not driven while selected");
   a_wr_single: assert property (reg_wr |=> !reg_wr)
      else $error("write pulse longer than one cycle");
   a_rd_single: assert property (reg_rd |=> !reg_rd)
      else $error("read pulse longer than one cycle");
   a_idle_quiet: assert property (
      ssel_n [*8] |-> !reg_wr && !reg_rd)
      else $error("core access while not selected");
   a_start_quiet: assert property (
      $fell(ssel_n) |-> (!reg_wr && !reg_rd) [*3])
      else $error("core access at start of selection");
   a_wr_rd_excl: assert property (!(reg_wr && reg_rd))
      else $error("read and write requested together");
   a_miso_hold: assert property (
      $rose(sclk) |=> $stable(miso_o) [*4])
      else $error("miso changed while serial clock high");
endmodule
bind radio_spi_slave_port spi_port_chk u_chk (.clk(clk), .rst_n(rst_n),
   .ssel_n(ssel_n), .sclk(sclk), .miso_o(miso_o), .miso_oe(miso_oe),
   .reg_wr(reg_wr), .reg_rd(reg_rd));

// ### spi_host_model.sv
/* host master model: drives select, serial clock and mosi at 160 ns.
   assumes a 20 ns core clock to pace its edges. */
`timescale 1ns/10ps
module spi_host_model (
   input  wire clk,
   output reg  ssel_n,
   output reg  sclk,
   output reg  mosi,
   input  wire miso_o,
   input  wire miso_oe
);
   reg  last_miso;
   // released line is not trusted: show the inverse of the last value
   wire miso_line = miso_oe ? miso_o : ~last_miso;
   initial begin
      ssel_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
      last_miso = 1'b0;
   end
   always @(posedge clk) begin
      if (miso_oe) last_miso <= miso_o;
   end
   task wait_clk(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task select(input reg on);
      begin
         wait_clk(1);
         ssel_n = !on;
         wait_clk(4);
      end
   endtask
   // 80 ns half period keeps the clock under both limits
   task xbit(input reg b, output reg r);
      begin
         mosi = b;
         wait_clk(4);
         sclk = 1'b1;
         r = miso_line;
         wait_clk(4);
         sclk = 1'b0;
      end
   endtask
   task xbyte(input [7:0] tx, output [7:0] rx);
      integer i;
      reg     r;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            xbit(tx[i], r);
            rx = {rx[6:0], r};
         end
      end
   endtask
   // clocks with select high: a refused case
   task idle_clk;
      reg r;
      begin
         repeat (8) xbit(1'b1, r);
      end
   endtask
endmodule

// ### test_radio_spi_slave_port.sv
/* self-checking bench for the serial slave port.
   assumes spi_host_model as host; core is a table addr ^ 5a. */
`timescale 1ns/10ps
module test_radio_spi_slave_port;
   reg         clk, rst_n;
   reg  [7:0]  irq_stat;
   reg  [7:0]  reg_rdata;
   wire        ssel_n, sclk, mosi, miso_o, miso_oe, reg_wr, reg_rd;
   wire [7:0]  reg_addr, reg_wdata;
   integer     errors, total_checks, cycles, nw, nr, i;
   reg  [15:0] wlog [0:15];
   reg  [7:0]  rlog [0:15];
   reg  [7:0]  tx [0:3];
   reg  [7:0]  rx [0:3];
   reg         r;
   radio_spi_slave_port u_dut (.clk(clk), .rst_n(rst_n), .ssel_n(ssel_n),
      .sclk(sclk), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe),
      .primary_irq_status(irq_stat), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   spi_host_model u_h (.clk(clk), .ssel_n(ssel_n), .sclk(sclk),
      .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe));
   initial clk = 1'b0;
   always #10 clk = ~clk;
   always @* reg_rdata = reg_addr ^ 8'h5a;
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (reg_wr === 1'b1 && nw < 16) begin
         wlog[nw] = {reg_addr, reg_wdata};
         nw = nw + 1;
      end
      if (reg_rd === 1'b1 && nr < 16) begin
         rlog[nr] = reg_addr;
         nr = nr + 1;
      end
      if (cycles == 12000) begin
         errors = errors + 1;
         report_and_stop;
      end
   end
   task chk(input [15:0] got, input [15:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task run(input integer n);
      begin
         nw = 0;
         nr = 0;
         u_h.select(1'b1);
         chk(miso_oe, 16'h0001);
         for (i = 0; i < n; i = i + 1) u_h.xbyte(tx[i], rx[i]);
         u_h.select(1'b0);
      end
   endtask
   task t_reg;
      begin
         irq_stat = 8'hc3;
         tx[0] = 8'h05; tx[1] = 8'haa; tx[2] = 8'h55;
         run(3);
         chk(rx[0], 16'h00c3);
         chk(nw, 2);
         chk(nr, 0);
         chk(wlog[0], 16'h05aa);
         chk(wlog[1], 16'h0655);
         irq_stat = 8'h3c;
         tx[0] = 8'h85; tx[1] = 8'h00; tx[2] = 8'h00;
         run(3);
         chk(rx[0], 16'h003c);
         chk({rx[1], rx[2]}, 16'h5f5c);
         chk(nw, 0);
         chk(nr, 3);
         chk({rlog[0], rlog[2]}, 16'h0507);
         tx[0] = 8'h3f; tx[1] = 8'h90; tx[2] = 8'h11;
         run(3);
         chk(nw, 1);
         chk(wlog[0], 16'h9011);
         tx[0] = 8'hbf;
         run(3);
         chk(rx[2], 16'h00ca);
         chk(nr, 2);
         chk({rlog[0], rlog[1]}, 16'h9091);
         $display("register tests done");
      end
   endtask
   task t_buf;
      begin
         tx[0] = 8'h40; tx[1] = 8'h11; tx[2] = 8'h22; tx[3] = 8'h33;
         run(4);
         tx[0] = 8'h60; tx[1] = 8'h05; tx[2] = 8'h99;
         run(3);
         chk(nw, 0);
         tx[0] = 8'hc0;
         run(4);
         chk({rx[1], rx[2]}, 16'h1122);
         chk(rx[3], 16'h0033);
         chk(nr, 0);
         tx[0] = 8'he0;
         run(3);
         chk(rx[2], 16'h0099);
         $display("buffer tests done");
      end
   endtask
   task t_abort;
      begin
         u_h.select(1'b1);
         repeat (4) u_h.xbit(1'b1, r);
         u_h.select(1'b0);
         tx[0] = 8'h02; tx[1] = 8'h77;
         run(2);
         chk(nw, 1);
         chk(wlog[0], 16'h0277);
         nw = 0;
         nr = 0;
         u_h.idle_clk;
         chk(nw, 0);
         chk(nr, 0);
         chk(miso_oe, 16'h0000);
         $display("abort and idle tests done");
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d errors %0d", total_checks, errors);
         if (errors == 0 && total_checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   initial begin
      errors = 0; total_checks = 0; cycles = 0; nw = 0; nr = 0;
      rst_n = 1'b0; irq_stat = 8'h00;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      u_h.wait_clk(3);
      t_reg;
      t_buf;
      t_abort;
      report_and_stop;
   end
endmodule
